// file: verilog/thg_pkg.sv
// constants and state type shared by the random word health gate
// assumes a single 250 MHz system clock and a synchronous reset
package thg_pkg;
  localparam int              CLK_MHZ      = 250;
  // raw noise sampling period and its cycle count
  localparam int              SAMPLE_NS    = 16;
  localparam int              SAMPLE_CYC   = (SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int              DIV_W        = 3;
  localparam logic [2:0]      DIV_LAST     = 3'(SAMPLE_CYC - 1);
  // equal consecutive raw samples that count as a dead source
  localparam int              RUN_W        = 6;
  localparam logic [5:0]      STUCK_LIM    = 6'h20;
  localparam logic [5:0]      RUN_ONE      = 6'h01;
  // statistical window: length and accepted ones count
  localparam int              WIN_W        = 9;
  localparam logic [8:0]      WIN_LAST     = 9'h0FF;
  localparam logic [8:0]      ONES_LO      = 9'h060;
  localparam logic [8:0]      ONES_HI      = 9'h0A0;
  localparam int              WIN_GAP_CYC  = 256 * 2 * SAMPLE_CYC;
  localparam int              GAP_W        = 12;
  // word assembly
  localparam int              WORD_W       = 16;
  localparam int              BCNT_W       = 5;
  localparam logic [4:0]      BCNT_BYTE    = 5'h08;
  localparam logic [4:0]      BCNT_WORD    = 5'h10;
  typedef enum logic [1:0] {
    THG_START = 2'b00,
    THG_PWRUP = 2'b01,
    THG_RUN   = 2'b11,
    THG_FAIL  = 2'b10
  } thg_state_t;
endpackage

// file: verilog/thg_window_test.sv
// windowed ones-count test over the internal bit stream
// assumes bit_en pulses one cycle per internal bit, same clock
module thg_window_test
  import thg_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // internal bit stream
  input  wire logic bit_en,
  input  wire logic bit_in,
  // verdict, one cycle after the last bit of each window
  output logic      win_done,
  output logic      win_pass
);
  logic [WIN_W-1:0] pos_ff;
  logic [WIN_W-1:0] ones_ff;
  logic             done_ff;
  logic             pass_ff;
  wire              last_bit = bit_en && (pos_ff == WIN_LAST);
  wire  [WIN_W-1:0] nxt_ones = ones_ff + {{(WIN_W-1){1'b0}}, bit_in};
  wire              in_band  = (nxt_ones >= ONES_LO) && (nxt_ones <= ONES_HI);

  // windows run back to back forever, so checking never pauses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pos_ff  <= 9'h000;
      ones_ff <= 9'h000;
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else begin
      done_ff <= last_bit;
      if (last_bit) begin
        pass_ff <= in_band;
        pos_ff  <= 9'h000;
        ones_ff <= 9'h000;
      end else if (bit_en) begin
        pos_ff  <= pos_ff + 9'h001;
        ones_ff <= nxt_ones;
      end
    end
  end

  assign win_done = done_ff;
  assign win_pass = pass_ff;
endmodule

// file: verilog/thg_gate.sv
// health gate between a physical noise source and the random word reader
// assumes noise_in is asynchronous; everything else is on clk_sys
//
// Contract
// - check for a dead noise source from the very first sample after start
// - after a dead source is seen, no random word is ever released
// - words holding bits taken after a source failure are never released
// - statistical test watches internal bits at start-up and all through operation
// - no word before power-up test passes; delivery stops on any defect
// - statistical test runs continuously, each window ends within a fixed time
// - random words are presented as 8 or 16 bits
// - internal bits carry average entropy above 0.997 per bit
module thg_gate
  import thg_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // noise source pin
  input  wire logic              noise_in,
  // reader side
  input  wire logic              word_wide,
  input  wire logic              rnd_take,
  output logic                   rnd_valid,
  output logic [WORD_W-1:0]      rnd_data,
  output logic                   rnd_wide,
  // health status
  output logic                   health_ok,
  output logic                   fail_total,
  output logic                   fail_stat,
  output logic                   pwrup_done
);
  thg_state_t         state_ff;
  thg_state_t         nxt_state;
  logic               s1_ff, s2_ff, s3_ff, raw_ff;
  logic [DIV_W-1:0]   div_ff;
  logic               last_ff, have_ff, phase_ff;
  logic [RUN_W-1:0]   run_ff;
  logic               ftot_ff, fstat_ff;
  logic [WORD_W-1:0]  sh_ff, pend_ff, out_ff;
  logic [BCNT_W-1:0]  cnt_ff;
  logic               wide_ff, pend_wide_ff, out_wide_ff;
  logic               pend_full_ff, valid_ff;
  logic [RUN_W-1:0]   guard_ff;
  logic               win_done, win_pass;

  // sampling enable and sample-level decodes
  wire smp_en   = (div_ff == DIV_LAST);
  wire same     = (raw_ff == last_ff);
  wire stuck    = (run_ff == STUCK_LIM);
  wire toggled  = smp_en && have_ff && !same;
  wire bit_en   = smp_en && phase_ff;
  wire ibit     = raw_ff ^ last_ff;
  wire stat_bad = win_done && !win_pass;
  wire fail_any = ftot_ff || fstat_ff || stuck || stat_bad;
  wire in_run   = (state_ff == THG_RUN);

  // word assembly decodes
  wire [BCNT_W-1:0] tgt     = wide_ff ? BCNT_WORD : BCNT_BYTE;
  wire              asm_en  = bit_en && in_run && !pend_full_ff;
  wire              wfirst  = (cnt_ff == 5'h00);
  wire              wlast   = asm_en && ((cnt_ff + 5'h01) == tgt);
  wire [WORD_W-1:0] nxt_sh  = {sh_ff[WORD_W-2:0], ibit};
  wire [WORD_W-1:0] wdata   = wide_ff ? nxt_sh : {8'h00, nxt_sh[7:0]};
  wire              guarded = (guard_ff == STUCK_LIM);
  // a word waits out one full stuck window of samples, so a dead source
  // behind any of its bits is always caught before release
  wire              release_w = pend_full_ff && guarded && in_run && !fail_any
                                && (!valid_ff || rnd_take);

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      raw_ff <= 1'b0;
    end else begin
      s1_ff  <= noise_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      raw_ff <= (s2_ff == s3_ff) ? s3_ff : raw_ff;
    end
  end

  // sample divider, run length of equal samples, bit pairing phase
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_ff   <= 3'h0;
      last_ff  <= 1'b0;
      have_ff  <= 1'b0;
      phase_ff <= 1'b0;
      run_ff   <= 6'h00;
    end else begin
      div_ff <= smp_en ? 3'h0 : div_ff + 3'h1;
      if (smp_en) begin
        last_ff  <= raw_ff;
        have_ff  <= 1'b1;
        phase_ff <= !phase_ff;
        if (!have_ff || !same)
          run_ff <= RUN_ONE;
        else if (!stuck)
          run_ff <= run_ff + 6'h01;
      end
    end
  end

  thg_window_test u_win (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .bit_en   (bit_en),
    .bit_in   (ibit),
    .win_done (win_done),
    .win_pass (win_pass)
  );

  // failure flags are sticky until reset: a flaky source must not recover silently
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ftot_ff  <= 1'b0;
      fstat_ff <= 1'b0;
    end else begin
      if (stuck)
        ftot_ff <= 1'b1;
      if (stat_bad)
        fstat_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      THG_START: if (fail_any) nxt_state = THG_FAIL;
                 else if (toggled) nxt_state = THG_PWRUP;
      THG_PWRUP: if (fail_any) nxt_state = THG_FAIL;
                 else if (win_done && win_pass) nxt_state = THG_RUN;
      THG_RUN:   if (fail_any) nxt_state = THG_FAIL;
      THG_FAIL:  nxt_state = THG_FAIL;
      default:   nxt_state = THG_FAIL;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) state_ff <= THG_START;
    else      state_ff <= nxt_state;
  end

  // word assembly and guard period
  always_ff @(posedge clk_sys) begin
    if (srst || fail_any) begin
      sh_ff        <= 16'h0000;
      cnt_ff       <= 5'h00;
      wide_ff      <= 1'b0;
      pend_ff      <= 16'h0000;
      pend_wide_ff <= 1'b0;
      pend_full_ff <= 1'b0;
      guard_ff     <= 6'h00;
    end else begin
      if (wfirst && !asm_en)
        wide_ff <= word_wide;
      if (wlast) begin
        pend_ff      <= wdata;
        pend_wide_ff <= wide_ff;
        pend_full_ff <= 1'b1;
        guard_ff     <= 6'h00;
        cnt_ff       <= 5'h00;
        sh_ff        <= 16'h0000;
      end else if (asm_en) begin
        sh_ff  <= nxt_sh;
        cnt_ff <= cnt_ff + 5'h01;
      end
      if (release_w)
        pend_full_ff <= 1'b0;
      else if (pend_full_ff && smp_en && !guarded)
        guard_ff <= guard_ff + 6'h01;
    end
  end

  // output slot: word held steady until taken
  always_ff @(posedge clk_sys) begin
    if (srst || fail_any) begin
      valid_ff    <= 1'b0;
      out_ff      <= 16'h0000;
      out_wide_ff <= 1'b0;
    end else if (release_w) begin
      valid_ff    <= 1'b1;
      out_ff      <= pend_ff;
      out_wide_ff <= pend_wide_ff;
    end else if (rnd_take) begin
      valid_ff    <= 1'b0;
    end
  end

  assign rnd_valid  = valid_ff;
  assign rnd_data   = out_ff;
  assign rnd_wide   = out_wide_ff;
  assign fail_total = ftot_ff;
  assign fail_stat  = fstat_ff;
  assign health_ok  = !ftot_ff && !fstat_ff;
  assign pwrup_done = in_run;

  // checking
  logic [GAP_W-1:0] gap_ff;
  always_ff @(posedge clk_sys) begin
    // counting starts with the first sample, so the first window is timed like the rest
    if (srst || win_done) gap_ff <= 12'h000;
    else if (have_ff)     gap_ff <= gap_ff + 12'h001;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  stuck_flags_a: assert property (stuck |=> fail_total && state_ff == THG_FAIL)
    else $error("dead source not flagged");
  dead_silent_a: assert property (fail_total |-> !rnd_valid)
    else $error("word valid after total failure");
  guard_release_a: assert property ($rose(rnd_valid) |-> $past(guard_ff) == STUCK_LIM)
    else $error("word released before guard elapsed");
  defect_flag_a: assert property (win_done && !win_pass |=> fail_stat ##0 !rnd_valid)
    else $error("statistical defect not flagged");
  pwrup_gate_a: assert property (rnd_valid |-> pwrup_done && $past(pwrup_done))
    else $error("word before power-up test passed");
  window_gap_a: assert property (gap_ff < WIN_GAP_CYC)
    else $error("statistical window overdue");
  byte_width_a: assert property (rnd_valid && !rnd_wide |-> rnd_data[15:8] == 8'h00)
    else $error("byte word has upper bits set");
  status_match_a: assert property (fail_any |=> !health_ok && (fail_total || fail_stat))
    else $error("failure not shown in status");
  word_hold_a: assert property (rnd_valid && !rnd_take && !fail_any |=> rnd_valid && $stable(rnd_data))
    else $error("word dropped before taken");
  valid_health_a: assert property (rnd_valid |-> health_ok)
    else $error("valid word while unhealthy");

  byte_out_c:  cover property (rnd_valid && !rnd_wide && rnd_take);
  word_out_c:  cover property (rnd_valid && rnd_wide && rnd_take);
  total_c:     cover property ($rose(fail_total));
  stat_c:      cover property ($rose(fail_stat));
endmodule

// file: bench/thg_reader_model.sv
// reader model: takes each valid word while health is good, promptly or slowly
// assumes the clk_sys domain; rnd_take changes just after the falling edge
module thg_reader_model
  import thg_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // word port
  input  wire logic              rnd_valid,
  input  wire logic [WORD_W-1:0] rnd_data,
  input  wire logic              rnd_wide,
  input  wire logic              health_ok,
  output logic                   rnd_take,
  // pacing and record
  input  wire logic [7:0]        slow,
  output logic [WORD_W-1:0]      last_data,
  output logic                   last_wide,
  output int                     taken_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_cnt;
  initial begin
    rnd_take  = 1'b0;
    wait_cnt  = 8'h00;
    taken_cnt = 0;
    last_data = '0;
    last_wide = 1'b0;
  end
  // take drops after every transfer, so a word that follows at once still waits its turn
  always @(negedge clk_sys) begin
    wait_cnt <= (srst || !rnd_valid || rnd_take) ? 8'h00 : wait_cnt + 8'h01;
    rnd_take <= !srst && !rnd_take && rnd_valid && health_ok && (wait_cnt >= slow);
  end
  always @(posedge clk_sys) begin
    if (rnd_valid && rnd_take) begin
      last_data <= rnd_data;
      last_wide <= rnd_wide;
      taken_cnt <= taken_cnt + 1;
    end
  end
endmodule

// file: bench/test_physical_trng_health_gate.sv
// self-checking bench for the random word health gate
// assumes thg_gate and the reader model; noise is a bench pattern changing every 4 cycles
module test_physical_trng_health_gate
  import thg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  logic              noise_in = 1'b0;
  logic              word_wide = 1'b0;
  logic              rnd_take;
  logic              rnd_valid;
  logic [WORD_W-1:0] rnd_data;
  logic              rnd_wide;
  logic              health_ok;
  logic              fail_total;
  logic              fail_stat;
  logic              pwrup_done;
  logic              pwr_q = 1'b0;
  logic [2:0]        flags;
  logic [7:0]        slow = 8'h00;
  logic [1:0]        mode = 2'h1;
  logic [1:0]        ph = 2'h0;
  logic [15:0]       lfsr = 16'hACE1;
  logic              tog = 1'b0;
  logic [WORD_W-1:0] last_data;
  logic              last_wide;
  int                taken_cnt;
  int                bad_count = 0;
  int                check_count = 0;
  int                cyc = 0;
  always #2 clk_sys = !clk_sys;
  // status bits that the scenarios wait on: 0 total failure, 1 statistical defect, 2 running
  assign flags = {pwrup_done, fail_stat, fail_total};
  thg_gate dut (.clk_sys(clk_sys), .srst(srst), .noise_in(noise_in), .word_wide(word_wide),
    .rnd_take(rnd_take), .rnd_valid(rnd_valid), .rnd_data(rnd_data), .rnd_wide(rnd_wide),
    .health_ok(health_ok), .fail_total(fail_total), .fail_stat(fail_stat), .pwrup_done(pwrup_done));
  thg_reader_model reader (.clk_sys(clk_sys), .srst(srst), .rnd_valid(rnd_valid), .rnd_data(rnd_data),
    .rnd_wide(rnd_wide), .health_ok(health_ok), .rnd_take(rnd_take), .slow(slow),
    .last_data(last_data), .last_wide(last_wide), .taken_cnt(taken_cnt));
  // mode 0 stuck low, 1 shift-register noise, 2 strict toggle that every pair turns into a one
  always @(negedge clk_sys) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tog  <= !tog;
    end
    noise_in <= (mode == 2'h0) ? 1'b0 : ((mode == 2'h1) ? lfsr[15] : tog);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a word may stand one cycle into a failure, never outside the running state otherwise
  always @(posedge clk_sys) begin
    cyc   <= cyc + 1;
    pwr_q <= pwrup_done;
    if (!srst && rnd_valid === 1'b1 && pwrup_done !== 1'b1 && pwr_q !== 1'b1) check(16'h1, 16'h0);
    if (cyc > 40000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic do_reset(input logic [1:0] m);
    mode = m;
    srst = 1'b1;
    repeat (12) @(negedge clk_sys);
    check({12'h0, rnd_valid, fail_total, fail_stat, pwrup_done}, 16'h0);
    srst = 1'b0;
    @(negedge clk_sys);
    check({15'h0, health_ok}, 16'h1);
  endtask
  task automatic wait_on(input logic [1:0] sel, input int lim);
    for (int i = 0; i < lim && flags[sel] !== 1'b1; i++) @(negedge clk_sys);
  endtask
  task automatic wait_takes(input int n);
    int t0;
    t0 = taken_cnt;
    for (int i = 0; i < 3000 && taken_cnt < t0 + n; i++) @(negedge clk_sys);
    check({15'h0, taken_cnt >= t0 + n}, 16'h1);
  endtask
  task automatic t_dead_start;
    do_reset(2'h0);
    wait_on(2'h0, 400);
    check({14'h0, fail_total, health_ok}, 16'h2);
    repeat (200) @(negedge clk_sys);
    check({14'h0, rnd_valid, pwrup_done}, 16'h0);
    $display("test dead_start done");
  endtask
  task automatic t_stat_defect;
    do_reset(2'h2);
    wait_on(2'h1, 3000);
    check({13'h0, fail_stat, fail_total, pwrup_done}, 16'h4);
    check({15'h0, health_ok}, 16'h0);
    $display("test stat_defect done");
  endtask
  // the size request is taken at the start of assembly, so the second word after a change is judged
  task automatic t_words;
    do_reset(2'h1);
    word_wide = 1'b0;
    slow = 8'h00;
    wait_on(2'h2, 3000);
    check({15'h0, pwrup_done}, 16'h1);
    wait_takes(2);
    check({last_wide, 7'h0, last_data[15:8]}, 16'h0);
    word_wide = 1'b1;
    slow = 8'h14;
    wait_takes(2);
    check({15'h0, last_wide}, 16'h1);
    repeat (2200) @(negedge clk_sys);
    check({14'h0, fail_stat, pwrup_done}, 16'h1);
    wait_takes(1);
    $display("test words done");
  endtask
  task automatic t_fail_run;
    int t0;
    mode = 2'h0;
    wait_on(2'h0, 400);
    check({14'h0, fail_total, pwrup_done}, 16'h2);
    t0 = taken_cnt;
    repeat (300) @(negedge clk_sys);
    check({15'h0, taken_cnt == t0}, 16'h1);
    check({15'h0, rnd_valid}, 16'h0);
    $display("test fail_run done");
  endtask
  initial begin
    t_dead_start();
    t_stat_defect();
    t_words();
    t_fail_run();
    final_report();
  end
endmodule
